// ===== hw/egs_divider.sv
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module egs_divider
	import egs_pkg::*;
(
	input wire logic sys_clk_in, // system clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic start_in, // one-cycle start pulse
	input wire logic [EGS_ACC_W-1:0] dividend_in, // unsigned dividend
	input wire logic [EGS_SET_W-1:0] divisor_in, // nonzero divisor
	output logic busy_out, // high while dividing
	output logic done_out, // one-cycle pulse when result valid
	output logic [EGS_ACC_W-1:0] quot_out, // quotient
	output logic [EGS_SET_W-1:0] rem_out // remainder
);
	logic [EGS_ACC_W-1:0] quot, next_quot;
	logic [EGS_SET_W:0] rem, next_rem;
	logic [EGS_SET_W-1:0] dvs, next_dvs;
	logic [6:0] cnt, next_cnt;
	logic busy, next_busy, done, next_done;
	logic [EGS_SET_W:0] trial;

	always_comb begin
		next_quot = quot;
		next_rem = rem;
		next_dvs = dvs;
		next_cnt = cnt;
		next_busy = busy;
		next_done = 1'b0;
		trial = {rem[EGS_SET_W-1:0], quot[EGS_ACC_W-1]};
		if (start_in && !busy) begin
			next_quot = dividend_in;
			next_rem = '0;
			next_dvs = divisor_in;
			next_cnt = EGS_DIV_STEPS;
			next_busy = 1'b1;
		end else if (busy) begin
			// remainder stays below divisor, so one extra bit suffices
			if (trial >= {1'b0, dvs}) begin
				next_rem = trial - {1'b0, dvs};
				next_quot = {quot[EGS_ACC_W-2:0], 1'b1};
			end else begin
				next_rem = trial;
				next_quot = {quot[EGS_ACC_W-2:0], 1'b0};
			end
			next_cnt = cnt - 7'h01;
			if (cnt == 7'h01) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			quot <= '0;
			rem <= '0;
			dvs <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			quot <= next_quot;
			rem <= next_rem;
			dvs <= next_dvs;
			cnt <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign busy_out = busy;
	assign done_out = done;
	assign quot_out = quot;
	assign rem_out = rem[EGS_SET_W-1:0];
endmodule // egs_divider

// ===== hw/egs_pkg.sv
// package: constants and types for the electronic gear scaler
package egs_pkg;
	localparam int EGS_SET_W = 31;
	localparam int EGS_CMD_W = 32;
	localparam int EGS_ACC_W = 64;
	localparam logic [EGS_SET_W-1:0] EGS_SET_MAX = 31'h40000000;
	localparam logic [EGS_SET_W-1:0] EGS_RES_17BIT = 31'h00020000;
	localparam logic [EGS_SET_W-1:0] EGS_RES_20BIT = 31'h00100000;
	localparam logic [EGS_SET_W-1:0] EGS_RATIO_LIMIT = 31'h000003E8;
	localparam logic [15:0] EGS_ALARM_CODE = 16'h0930;
	localparam logic [6:0] EGS_DIV_STEPS = 7'h40;
	typedef enum logic [1:0] {
		EGS_MODE_POSITION = 2'b00,
		EGS_MODE_SPEED = 2'b01,
		EGS_MODE_TORQUE = 2'b10,
		EGS_MODE_FULL_CLOSING = 2'b11
	} egs_mode_t;
	typedef enum logic [1:0] {
		EGS_ST_IDLE = 2'b00,
		EGS_ST_DIV = 2'b01,
		EGS_ST_DONE = 2'b10
	} egs_state_t;
endpackage

// ===== hw/egs_scaler.sv
// electronic gear scaler: command scaling and feedback division with remainder carry
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Position and full closing modes: command times gear ratio drives motor position.
// [RULE2] Speed and torque modes: encoder pulses divided by ratio give command-unit feedback.
// [RULE3] Zero numerator uses encoder resolution: 131072 (17-bit) or 1048576 (20-bit).
// [RULE4] Zero-numerator substitution also holds in full closing mode.
// [RULE5] Effective ratio outside 1/1000..1000 raises parameter setting alarm 93.0.
// [RULE6] Zero numerator: scale is encoder resolution over denominator.
// [RULE7] Nonzero numerator: scale is numerator over denominator; settings up to 1073741824.
// [RULE8] Division remainder carries to next sample so no position is lost; the code drops the carry on a direction change and while alarmed.
module egs_scaler
	import egs_pkg::*;
(
	input wire logic sys_clk_in, // 25 MHz system clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic [1:0] ctrl_mode_in, // control mode, egs_mode_t coding
	input wire logic enc_20bit_in, // 1: 20-bit incremental, 0: 17-bit absolute
	input wire logic [EGS_SET_W-1:0] gear_ratio_numerator_in, // gear numerator setting
	input wire logic [EGS_SET_W-1:0] gear_ratio_denominator_in, // gear denominator setting
	input wire logic cmd_valid_in, // one-cycle pulse with a position command delta
	input wire logic signed [EGS_CMD_W-1:0] cmd_delta_in, // command delta in command units
	input wire logic fb_valid_in, // one-cycle pulse with an encoder delta
	input wire logic signed [EGS_CMD_W-1:0] fb_delta_in, // encoder delta in pulses
	output logic cmd_ready_out, // scaler idle, a sample may be given
	output logic pos_valid_out, // one-cycle pulse, scaled result ready
	output logic pos_is_fb_out, // result is feedback (1) or motor command (0)
	output logic signed [EGS_CMD_W-1:0] pos_delta_out, // scaled delta
	output logic alarm_out, // parameter setting alarm, level
	output logic [15:0] alarm_code_out // alarm number, zero when clear
);
	egs_state_t state, next_state;
	logic [EGS_SET_W-1:0] rem_cmd, next_rem_cmd, rem_fb, next_rem_fb;
	logic is_fb, next_is_fb, neg, next_neg;
	logic [EGS_ACC_W-1:0] dividend, next_dividend;
	logic [EGS_SET_W-1:0] divisor, next_divisor;
	logic start, next_start;
	logic ready, next_ready;
	logic pvalid, next_pvalid;
	logic signed [EGS_CMD_W-1:0] pdelta, next_pdelta;
	logic alarm, next_alarm;
	logic [15:0] alarm_code, next_alarm_code;
	logic [EGS_SET_W-1:0] num_eff, den;
	logic ratio_bad, pos_mode;
	logic [EGS_CMD_W-1:0] mag;
	logic [EGS_ACC_W-1:0] prod;
	logic dv_done;
	logic [EGS_ACC_W-1:0] dv_quot;
	logic [EGS_SET_W-1:0] dv_rem;

	always_comb begin
		// zero numerator falls back to encoder resolution in every mode
		if (gear_ratio_numerator_in == '0) begin // see [RULE3] see [RULE4] see [RULE6]
			num_eff = enc_20bit_in ? EGS_RES_20BIT : EGS_RES_17BIT;
		end else begin
			num_eff = gear_ratio_numerator_in; // see [RULE7]
		end
		den = gear_ratio_denominator_in;
		// compare by cross products; both fit 41 bits, well inside 64
		ratio_bad = (den == '0) || (gear_ratio_numerator_in > EGS_SET_MAX) || (den > EGS_SET_MAX)
			|| ({33'h0, num_eff} > {33'h0, den} * {33'h0, EGS_RATIO_LIMIT})
			|| ({33'h0, den} > {33'h0, num_eff} * {33'h0, EGS_RATIO_LIMIT}); // see [RULE5]
		pos_mode = (ctrl_mode_in == EGS_MODE_POSITION) || (ctrl_mode_in == EGS_MODE_FULL_CLOSING);
		next_alarm = ratio_bad; // see [RULE5]
		// the code is registered beside the flag so the port needs no decode
		next_alarm_code = ratio_bad ? EGS_ALARM_CODE : 16'h0000; // see [RULE5]
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			alarm <= 1'b0;
			alarm_code <= 16'h0000;
		end else begin
			alarm <= next_alarm;
			alarm_code <= next_alarm_code;
		end
	end

	always_comb begin
		next_state = state;
		next_rem_cmd = rem_cmd;
		next_rem_fb = rem_fb;
		next_is_fb = is_fb;
		next_neg = neg;
		next_dividend = dividend;
		next_divisor = divisor;
		next_start = 1'b0;
		next_pvalid = 1'b0;
		next_pdelta = pdelta;
		next_ready = ready;
		mag = '0;
		prod = '0;
		unique case (state)
			EGS_ST_IDLE: begin
				next_ready = 1'b1;
				// while alarmed the ratio is meaningless, so samples are dropped
				if (!alarm && !ratio_bad) begin
					if (pos_mode && cmd_valid_in) begin // see [RULE1]
						mag = cmd_delta_in[EGS_CMD_W-1] ? EGS_CMD_W'(-cmd_delta_in) : cmd_delta_in;
						next_neg = cmd_delta_in[EGS_CMD_W-1];
						prod = {32'h0, mag} * {33'h0, num_eff};
						next_dividend = prod + {33'h0, rem_cmd}; // see [RULE8]
						next_divisor = den;
						next_is_fb = 1'b0;
						next_start = 1'b1;
						next_ready = 1'b0;
						next_state = EGS_ST_DIV;
					end else if (!pos_mode && fb_valid_in) begin // see [RULE2]
						mag = fb_delta_in[EGS_CMD_W-1] ? EGS_CMD_W'(-fb_delta_in) : fb_delta_in;
						next_neg = fb_delta_in[EGS_CMD_W-1];
						prod = {32'h0, mag} * {33'h0, den};
						next_dividend = prod + {33'h0, rem_fb}; // see [RULE8]
						next_divisor = num_eff;
						next_is_fb = 1'b1;
						next_start = 1'b1;
						next_ready = 1'b0;
						next_state = EGS_ST_DIV;
					end
				end
			end
			EGS_ST_DIV: begin
				if (dv_done) begin
					// remainder is kept as a magnitude; sign changes restart accumulation
					if (is_fb) begin
						next_rem_fb = dv_rem; // see [RULE8]
					end else begin
						next_rem_cmd = dv_rem; // see [RULE8]
					end
					next_pdelta = neg ? EGS_CMD_W'(-dv_quot[EGS_CMD_W-1:0]) : dv_quot[EGS_CMD_W-1:0];
					next_pvalid = 1'b1;
					next_state = EGS_ST_DONE;
				end
			end
			EGS_ST_DONE: begin
				next_ready = 1'b1;
				next_state = EGS_ST_IDLE;
			end
			default: begin
				next_state = EGS_ST_IDLE;
			end
		endcase
		// a direction change or alarm drops the fractional carry
		if (state == EGS_ST_IDLE && next_start && next_neg != neg) begin
			if (next_is_fb) begin
				next_rem_fb = '0;
				next_dividend = prod;
			end else begin
				next_rem_cmd = '0;
				next_dividend = prod;
			end
		end
		if (alarm) begin
			next_rem_cmd = '0;
			next_rem_fb = '0;
		end
		// gating here keeps the ready port straight off a flop
		next_ready = next_ready && !next_alarm; // see [RULE5]
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			state <= EGS_ST_IDLE;
			rem_cmd <= '0;
			rem_fb <= '0;
			is_fb <= 1'b0;
			neg <= 1'b0;
			dividend <= '0;
			divisor <= '0;
			start <= 1'b0;
			ready <= 1'b0;
			pvalid <= 1'b0;
			pdelta <= '0;
		end else begin
			state <= next_state;
			rem_cmd <= next_rem_cmd;
			rem_fb <= next_rem_fb;
			is_fb <= next_is_fb;
			neg <= next_neg;
			dividend <= next_dividend;
			divisor <= next_divisor;
			start <= next_start;
			ready <= next_ready;
			pvalid <= next_pvalid;
			pdelta <= next_pdelta;
		end
	end

	egs_divider u_div (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.start_in(start),
		.dividend_in(dividend),
		.divisor_in(divisor),
		.busy_out(),
		.done_out(dv_done),
		.quot_out(dv_quot),
		.rem_out(dv_rem)
	);

	assign cmd_ready_out = ready;
	assign pos_valid_out = pvalid;
	assign pos_is_fb_out = is_fb;
	assign pos_delta_out = pdelta;
	assign alarm_out = alarm;
	assign alarm_code_out = alarm_code;
endmodule // egs_scaler

// ===== test/egs_host_model.sv
// host model: one command pulse per request once the scaler is ready
`timescale 1ns/1ps
module egs_host_model
	import egs_pkg::*;
(
	input wire logic sys_clk_in, // clock
	input wire logic rst_n_in, // reset
	input wire logic send_in, // request
	input wire logic signed [EGS_CMD_W-1:0] delta_in, // delta
	input wire logic cmd_ready_in, // ready
	output logic cmd_valid_out, // pulse
	output logic signed [EGS_CMD_W-1:0] cmd_delta_out // delta
);
	logic pending;
	logic signed [EGS_CMD_W-1:0] held;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			pending <= 1'b0;
			cmd_valid_out <= 1'b0;
			cmd_delta_out <= 32'h0;
		end else if (send_in) begin
			pending <= 1'b1;
			held <= delta_in;
		end else if (pending && cmd_ready_in) begin
			pending <= 1'b0;
			cmd_valid_out <= 1'b1;
			cmd_delta_out <= held;
		end else begin
			cmd_valid_out <= 1'b0;
			// idle data is garbage so a stale value cannot pass
			cmd_delta_out <= ~cmd_delta_out;
		end
	end
endmodule // egs_host_model

// ===== test/egs_scaler_properties.sv
// checker: port-level properties of the gear scaler
`timescale 1ns/1ps
module egs_scaler_properties
	import egs_pkg::*;
(
	input wire logic sys_clk_in, // clock
	input wire logic rst_n_in, // reset
	input wire logic [1:0] ctrl_mode_in, // mode
	input wire logic [EGS_SET_W-1:0] gear_ratio_denominator_in, // den
	input wire logic cmd_valid_in, // cmd pulse
	input wire logic fb_valid_in, // fb pulse
	input wire logic cmd_ready_out, // ready
	input wire logic pos_valid_out, // result pulse
	input wire logic pos_is_fb_out, // result kind
	input wire logic signed [EGS_CMD_W-1:0] pos_delta_out, // result
	input wire logic alarm_out, // alarm
	input wire logic [15:0] alarm_code_out // alarm number
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence cmd_take;
		cmd_ready_out && cmd_valid_in && (ctrl_mode_in[0] == ctrl_mode_in[1]);
	endsequence
	sequence fb_take;
		cmd_ready_out && fb_valid_in && (ctrl_mode_in[0] != ctrl_mode_in[1]);
	endsequence
	cmd_answer_a: assert property (cmd_take |-> ##[65:68] (pos_valid_out && !pos_is_fb_out))
		else $error("command result missing");
	fb_answer_a: assert property (fb_take |-> ##[65:68] (pos_valid_out && pos_is_fb_out))
		else $error("feedback result missing");
	alarm_code_a: assert property (alarm_code_out == (alarm_out ? EGS_ALARM_CODE : 16'h0000))
		else $error("alarm code wrong");
	den_zero_a: assert property ((gear_ratio_denominator_in == 31'h0) [*3] |-> alarm_out)
		else $error("zero denominator not alarmed");
	alarm_block_a: assert property (alarm_out |-> !cmd_ready_out)
		else $error("ready while alarmed");
	valid_pulse_a: assert property (pos_valid_out |=> !pos_valid_out)
		else $error("result pulse too long");
	delta_hold_a: assert property (!pos_valid_out |-> $stable(pos_delta_out))
		else $error("result changed without pulse");
	ready_back_a: assert property (pos_valid_out && !alarm_out |=> cmd_ready_out)
		else $error("ready not restored");
endmodule // egs_scaler_properties
bind egs_scaler egs_scaler_properties egs_scaler_properties_inst (.sys_clk_in, .rst_n_in, .ctrl_mode_in,
	.gear_ratio_denominator_in, .cmd_valid_in, .fb_valid_in, .cmd_ready_out, .pos_valid_out, .pos_is_fb_out,
	.pos_delta_out, .alarm_out, .alarm_code_out);

// ===== test/tb_top.sv
// testbench: gear scaling, feedback division, remainder carry and alarm
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
	import egs_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [1:0] mode = 2'b00;
	logic enc20 = 1'b0;
	logic [30:0] num = 31'h1;
	logic [30:0] den = 31'h1;
	logic send = 1'b0;
	logic fbv = 1'b0;
	logic signed [31:0] sd = 32'h0;
	logic signed [31:0] fbd = 32'h0;
	logic cmd_valid, ready, pv, isfb, alarm;
	logic signed [31:0] cmd_delta, pos_delta;
	logic [15:0] code;
	int fail_count = 0;
	int check_count = 0;
	egs_scaler egs_scaler_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ctrl_mode_in(mode),
		.enc_20bit_in(enc20), .gear_ratio_numerator_in(num), .gear_ratio_denominator_in(den),
		.cmd_valid_in(cmd_valid), .cmd_delta_in(cmd_delta), .fb_valid_in(fbv), .fb_delta_in(fbd),
		.cmd_ready_out(ready), .pos_valid_out(pv), .pos_is_fb_out(isfb), .pos_delta_out(pos_delta),
		.alarm_out(alarm), .alarm_code_out(code));
	egs_host_model egs_host_model_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .send_in(send),
		.delta_in(sd), .cmd_ready_in(ready), .cmd_valid_out(cmd_valid), .cmd_delta_out(cmd_delta));
	initial begin
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cfg(input logic [1:0] m, input logic e, input logic [30:0] n, input logic [30:0] d);
		@(posedge sys_clk_in);
		mode <= m;
		enc20 <= e;
		num <= n;
		den <= d;
		repeat (3) @(posedge sys_clk_in);
	endtask
	task automatic run(input logic f, input logic signed [31:0] d, input logic signed [31:0] exp);
		int i;
		@(posedge sys_clk_in);
		if (f) fbv <= 1'b1;
		else send <= 1'b1;
		fbd <= d;
		sd <= d;
		@(posedge sys_clk_in);
		fbv <= 1'b0;
		send <= 1'b0;
		fbd <= ~d;
		for (i = 0; i < 100 && pv !== 1'b1; i++) @(negedge sys_clk_in);
		`CHK(pv, 1'b1)
		`CHK(pos_delta, exp)
		`CHK(isfb, f)
		@(posedge sys_clk_in);
	endtask
	task automatic s_gear();
		cfg(EGS_MODE_POSITION, 1'b0, 31'h3, 31'h2);
		run(1'b0, 32'h0000000A, 32'h0000000F);
		run(1'b0, 32'hFFFFFFFC, 32'hFFFFFFFA);
		cfg(EGS_MODE_FULL_CLOSING, 1'b0, 31'h0, 31'h400);
		run(1'b0, 32'h00000005, 32'h00000280);
		cfg(EGS_MODE_POSITION, 1'b1, 31'h0, 31'h800);
		run(1'b0, 32'h00000003, 32'h00000600);
	endtask
	task automatic s_feedback();
		cfg(EGS_MODE_SPEED, 1'b0, 31'h4, 31'h1);
		run(1'b1, 32'h00000064, 32'h00000019);
		cfg(EGS_MODE_TORQUE, 1'b1, 31'h0, 31'h800);
		run(1'b1, 32'h00001000, 32'h00000008);
	endtask
	task automatic s_carry();
		cfg(EGS_MODE_POSITION, 1'b0, 31'h1, 31'h3);
		run(1'b0, 32'h1, 32'h0);
		run(1'b0, 32'h1, 32'h0);
		run(1'b0, 32'h1, 32'h1);
		run(1'b0, 32'h1, 32'h0);
	endtask
	task automatic s_alarm();
		logic [30:0] n[7] = '{31'h3E9, 31'h3E8, 31'h1, 31'h1, 31'h0, 31'h0, 31'h40000001};
		logic [30:0] d[7] = '{31'h1, 31'h1, 31'h3E8, 31'h3E9, 31'h84, 31'h83, 31'h1};
		logic a[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
		int seen;
		for (int k = 0; k < 7; k++) begin
			cfg(EGS_MODE_POSITION, 1'b0, n[k], d[k]);
			@(negedge sys_clk_in);
			`CHK(alarm, a[k])
			`CHK(code, a[k] ? EGS_ALARM_CODE : 16'h0000)
			`CHK(ready, !a[k])
		end
		cfg(EGS_MODE_SPEED, 1'b0, 31'h1, 31'h0);
		fbv <= 1'b1;
		@(posedge sys_clk_in);
		fbv <= 1'b0;
		seen = 0;
		repeat (80) @(negedge sys_clk_in) seen += (pv !== 1'b0);
		`CHK(seen, 0)
		// alarm discards the remainder left by the carry scenario
		cfg(EGS_MODE_POSITION, 1'b0, 31'h1, 31'h3);
		run(1'b0, 32'h2, 32'h0);
	endtask
	task automatic s_reset();
		int seen;
		// reset lands in the middle of a division while a remainder of two is held, and clears it
		@(posedge sys_clk_in);
		send <= 1'b1;
		sd <= 32'h1;
		@(posedge sys_clk_in);
		send <= 1'b0;
		repeat (10) @(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK(pv, 1'b0)
		`CHK(ready, 1'b0)
		`CHK(alarm, 1'b0)
		`CHK(code, 16'h0000)
		`CHK(pos_delta, 32'h0)
		@(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		seen = 0;
		repeat (80) @(negedge sys_clk_in) seen += (pv !== 1'b0);
		`CHK(seen, 0)
		run(1'b0, 32'h1, 32'h0);
	endtask
	initial begin
		#(40 * 20000);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		s_gear();
		s_feedback();
		s_carry();
		s_alarm();
		s_reset();
		summarize();
	end
endmodule // tb_top
